// ===== include/sdc_pkg.sv
/*
  Shared constants and types for the stereo converter control block.
  Assumes a single 100 MHz bus clock that also serves as the master clock.
*/
package sdc_pkg;
  // Bus register byte offsets.
  localparam logic [7:0] OFF_VOL_L  = 8'h00;
  localparam logic [7:0] OFF_VOL_R  = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LEFT   = 8'h10;
  localparam logic [7:0] OFF_RIGHT  = 8'h14;

  // Serial control word layout.
  localparam int         CTL_WORD_W = 16;
  localparam int         REG_W      = 14;
  localparam logic [1:0] SEL_VOL_L  = 2'h0;
  localparam logic [1:0] SEL_VOL_R  = 2'h1;
  localparam logic [1:0] SEL_CTRL   = 2'h2;

  // Control register field positions.
  localparam int CB_CURVE   = 0;
  localparam int CB_FMT     = 4;
  localparam int CB_MUTE    = 6;
  localparam int CB_AUTODIV = 7;
  localparam int CB_WLEN    = 8;
  localparam int CB_RATE96  = 10;
  localparam int CB_RATE192 = 11;

  // Reset values.
  localparam logic [13:0] VOL_RST  = 14'h3fff;
  localparam logic [13:0] CTRL_RST = 14'h0080;

  // Status register field positions.
  localparam int SB_FLAGS = 0;
  localparam int SB_RATE  = 2;
  localparam int SB_DEEMPHASIS_ENABLE = 4;
  localparam int SB_CURVE = 5;
  localparam int SB_MUTE  = 7;
  localparam int SB_FMT   = 8;
  localparam int SB_DIV   = 10;
  localparam int SB_FAULT = 13;

  // Audio framing and silence detection.
  localparam int         SAMPLE_W      = 24;
  localparam int         SILENCE_LIMIT = 1024;
  localparam logic [5:0] SKIP_I2S      = 6'h01;
  localparam logic [5:0] SKIP_RJ24     = 6'h08;
  localparam logic [5:0] SKIP_RJ20     = 6'h0c;
  localparam logic [5:0] SKIP_RJ16     = 6'h10;
  localparam logic [1:0] WLEN_20       = 2'h1;
  localparam logic [1:0] WLEN_16       = 2'h2;

  // Master clock ratio classes, normalised to the 48 kHz base.
  localparam logic [13:0] RATIO_MIN = 14'h00c0;
  localparam logic [13:0] RATIO_T1  = 14'h0140;
  localparam logic [13:0] RATIO_T2  = 14'h01c0;
  localparam logic [13:0] RATIO_T3  = 14'h0280;
  localparam logic [13:0] RATIO_T4  = 14'h0380;
  localparam logic [13:0] RATIO_MAX = 14'h0500;

  typedef enum logic [1:0] {FMT_RJ, FMT_I2S, FMT_LJ, FMT_DSP} sdc_fmt_t;
  typedef enum logic [1:0] {RATE_48, RATE_96, RATE_192} sdc_rate_t;
endpackage : sdc_pkg

// ===== logic/sdc_ctrl_port.sv
/*
  Three-wire serial control port: shifts a word in and hands it on at the latch.
  Assumes its inputs are already resampled onto pclk.
*/
`timescale 1ns/1ps
module sdc_ctrl_port (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Resampled control pins.
  input  wire logic        shift_clk,
  input  wire logic        serial_in,
  input  wire logic        word_latch,
  // Completed word.
  output logic [15:0]      word,
  output logic             word_valid
);
  logic        prev_clk;
  logic        prev_latch;
  logic [15:0] shreg;
  logic        next_prev_clk;
  logic        next_prev_latch;
  logic [15:0] next_shreg;
  logic [15:0] next_word;
  logic        next_valid;
  logic        latch_rise;

  assign latch_rise = word_latch & ~prev_latch;

  // Shift on each clock rise, gated or free running; move the word at the latch rise.
  always_comb begin
    next_prev_clk   = shift_clk;
    next_prev_latch = word_latch;
    next_shreg      = shreg;
    next_word       = word;
    next_valid      = 1'b0;
    if (shift_clk && !prev_clk) begin
      next_shreg = {shreg[14:0], serial_in};
    end
    if (latch_rise) begin
      next_word  = shreg;
      next_valid = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_clk   <= 1'b0;
      prev_latch <= 1'b0;
      shreg      <= 16'h0000;
      word       <= 16'h0000;
      word_valid <= 1'b0;
    end else begin
      prev_clk   <= next_prev_clk;
      prev_latch <= next_prev_latch;
      shreg      <= next_shreg;
      word       <= next_word;
      word_valid <= next_valid;
    end
  end

  // A latch rise yields exactly one strobe carrying the shifted bits.
  sequence s_latch_rise;
    latch_rise ##0 !(shift_clk && !prev_clk);
  endsequence
  a_latch_word_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_latch_rise |=> word_valid && word == $past(shreg) ##1 !word_valid)
    else $error("latched control word not delivered");
endmodule : sdc_ctrl_port

// ===== logic/sdc_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes each bit changes slowly compared with the clock.
*/
`timescale 1ns/1ps
module sdc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pins in, resampled levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  // The first stage feeds only the second stage.
  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end
endmodule : sdc_sync

// ===== logic/sdc_top.sv
/*
  Digital control of a stereo audio converter: control registers, pin
  configuration, serial audio receiver, silence flags and clock ratio check.
  Assumes pclk is the master clock and all audio and control pins are asynchronous.
*/
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module sdc_top #(
  parameter int SILENCE_LIMIT = sdc_pkg::SILENCE_LIMIT
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Register bus.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial control pins.
  input  wire logic        control_shift_clock,
  input  wire logic        control_serial_in,
  input  wire logic        control_word_latch,
  // Serial audio pins.
  input  wire logic        audio_bit_clock,
  input  wire logic        audio_lr_clock,
  input  wire logic        serial_audio_in,
  // Configuration pins.
  input  wire logic        rate_192_sel,
  input  wire logic        rate_96_sel,
  input  wire logic        deemphasis_enable,
  input  wire logic        mute_in,
  input  wire logic        input_format_sel_hi,
  input  wire logic        input_format_sel_lo,
  // Status and samples.
  output logic             left_silence_flag,
  output logic             right_silence_flag,
  output logic      [23:0] left_sample,
  output logic      [23:0] right_sample,
  output logic             sample_strobe,
  // Settings for the converter datapath.
  output logic      [13:0] vol_left,
  output logic      [13:0] vol_right,
  output logic      [1:0]  rate_mode,
  output logic             deemph_active,
  output logic      [1:0]  deemph_curve,
  output logic             mute_out,
  output logic      [1:0]  format_active,
  output logic      [2:0]  mclk_div_idx,
  output logic             clock_fault
);
  localparam int CNT_W = $clog2(SILENCE_LIMIT + 2);
  localparam logic [CNT_W-1:0] LIM = CNT_W'(SILENCE_LIMIT);

  if (SILENCE_LIMIT < 1 || SILENCE_LIMIT > 65534) begin : g_check
    $error("SILENCE_LIMIT out of range");
  end

  // Left-aligns a word that held fewer than the full sample bits.
  function automatic logic [23:0] sdc_align(input logic [23:0] sh, input logic [4:0] n);
    sdc_align = (n == 5'd0) ? 24'h000000 : sh << (5'd24 - n);
  endfunction : sdc_align

  // Bits to skip after a channel change, per format and word length.
  function automatic logic [5:0] sdc_skip(input logic [1:0] fmt, input logic [1:0] wl);
    if (fmt == sdc_pkg::FMT_I2S) sdc_skip = sdc_pkg::SKIP_I2S;
    else if (fmt != sdc_pkg::FMT_RJ) sdc_skip = 6'h00;
    else if (wl == sdc_pkg::WLEN_20) sdc_skip = sdc_pkg::SKIP_RJ20;
    else if (wl == sdc_pkg::WLEN_16) sdc_skip = sdc_pkg::SKIP_RJ16;
    else sdc_skip = sdc_pkg::SKIP_RJ24;
  endfunction : sdc_skip

  // Pins pass two flip-flops before any logic reads them.
  logic [11:0] s_pin;
  sdc_sync #(.W(12)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({control_shift_clock, control_serial_in, control_word_latch,
                audio_bit_clock, audio_lr_clock, serial_audio_in, rate_192_sel,
                rate_96_sel, deemphasis_enable, mute_in, input_format_sel_hi,
                input_format_sel_lo}),
    .q       (s_pin)
  );
  logic s_bclk, s_lr, s_data, s_192, s_96, s_deemphasis_enable, s_mute;
  logic [1:0] s_fmt;
  assign {s_bclk, s_lr, s_data, s_192, s_96, s_deemphasis_enable, s_mute, s_fmt} = s_pin[8:0];

  // Serial control port.
  logic [15:0] cword;
  logic        cword_valid;
  sdc_ctrl_port u_ctrl (
    .pclk       (pclk),
    .presetn    (presetn),
    .shift_clk  (s_pin[11]),
    .serial_in  (s_pin[10]),
    .word_latch (s_pin[9]),
    .word       (cword),
    .word_valid (cword_valid)
  );

  // Register file and bus slave.
  logic [13:0] ctrl_reg, next_ctrl, next_vol_l, next_vol_r;
  logic [31:0] next_prdata, status;
  logic        bus_wr, mapped;
  assign pready = 1'b1;
  assign bus_wr = psel & penable & pwrite;
  assign mapped = paddr inside {sdc_pkg::OFF_VOL_L, sdc_pkg::OFF_VOL_R,
                  sdc_pkg::OFF_CTRL, sdc_pkg::OFF_STATUS, sdc_pkg::OFF_LEFT,
                  sdc_pkg::OFF_RIGHT};
  assign pslverr = psel & penable & ~mapped;
  assign status = 32'({clock_fault, mclk_div_idx, format_active, mute_out,
                  deemph_curve, deemph_active, rate_mode, right_silence_flag,
                  left_silence_flag});

  // Serial words and bus writes update the registers; the serial word wins a tie.
  always_comb begin
    next_vol_l  = vol_left;
    next_vol_r  = vol_right;
    next_ctrl   = ctrl_reg;
    next_prdata = prdata;
    if (bus_wr && paddr == sdc_pkg::OFF_VOL_L) next_vol_l = pwdata[13:0];
    if (bus_wr && paddr == sdc_pkg::OFF_VOL_R) next_vol_r = pwdata[13:0];
    if (bus_wr && paddr == sdc_pkg::OFF_CTRL) next_ctrl = pwdata[13:0];
    if (cword_valid) begin
      case (cword[1:0])
        sdc_pkg::SEL_VOL_L: next_vol_l = cword[15:2];
        sdc_pkg::SEL_VOL_R: next_vol_r = cword[15:2];
        sdc_pkg::SEL_CTRL:  next_ctrl = cword[15:2];
        default:            ; // Select 11 is ignored, so a same-cycle bus write stands.
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        sdc_pkg::OFF_VOL_L:  next_prdata = {18'h00000, vol_left};
        sdc_pkg::OFF_VOL_R:  next_prdata = {18'h00000, vol_right};
        sdc_pkg::OFF_CTRL:   next_prdata = {18'h00000, ctrl_reg};
        sdc_pkg::OFF_STATUS: next_prdata = status;
        sdc_pkg::OFF_LEFT:   next_prdata = {8'h00, left_sample};
        sdc_pkg::OFF_RIGHT:  next_prdata = {8'h00, right_sample};
        default:             next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vol_left  <= sdc_pkg::VOL_RST;
      vol_right <= sdc_pkg::VOL_RST;
      ctrl_reg  <= sdc_pkg::CTRL_RST;
      prdata    <= 32'h00000000;
    end else begin
      vol_left  <= next_vol_l;
      vol_right <= next_vol_r;
      ctrl_reg  <= next_ctrl;
      prdata    <= next_prdata;
    end
  end

  // Pin and register settings merge into the working configuration.
  logic [1:0] next_rate, next_fmt, next_curve, next_div;
  logic       next_deemphasis_enable, next_mute;
  always_comb begin
    if (s_192 || ctrl_reg[sdc_pkg::CB_RATE192]) next_rate = sdc_pkg::RATE_192;
    else if (s_96 || ctrl_reg[sdc_pkg::CB_RATE96]) next_rate = sdc_pkg::RATE_96;
    else next_rate = sdc_pkg::RATE_48;
    if (ctrl_reg[sdc_pkg::CB_FMT +: 2] == 2'h0) next_fmt = s_fmt;
    else next_fmt = ctrl_reg[sdc_pkg::CB_FMT +: 2];
    next_deemphasis_enable = s_deemphasis_enable;
    next_curve = (ctrl_reg[sdc_pkg::CB_CURVE +: 2] == 2'h3) ? 2'h0
                 : ctrl_reg[sdc_pkg::CB_CURVE +: 2];
    next_mute  = s_mute | ctrl_reg[sdc_pkg::CB_MUTE] | clock_fault;
  end

  // Receiver state: bit position, shift register and channel tracking.
  logic        prev_bclk, prev_lr, edge_lr, dsp_act, dsp_left;
  logic [5:0]  bit_idx, idx;
  logic [4:0]  nbits, nb;
  logic [23:0] sh, aligned;
  logic        smp_edge, done, done_left;
  logic        next_edge_lr, next_dsp_act, next_dsp_left, next_strobe;
  logic [5:0]  next_idx;
  logic [4:0]  next_nbits;
  logic [23:0] next_sh, next_left, next_right;
  assign smp_edge = (format_active == sdc_pkg::FMT_DSP) ? (prev_bclk & ~s_bclk)
                    : (s_bclk & ~prev_bclk);
  assign aligned  = sdc_align(sh, nbits);

  // Bits are taken only on bit clock edges, so gaps in the bit clock are harmless.
  always_comb begin
    idx = bit_idx;
    nb = nbits;
    done = 1'b0;
    done_left = 1'b0;
    next_edge_lr = edge_lr;
    next_dsp_act = dsp_act;
    next_dsp_left = dsp_left;
    next_idx = bit_idx;
    next_nbits = nbits;
    next_sh = sh;
    if (smp_edge) begin
      next_edge_lr = s_lr;
      if (format_active == sdc_pkg::FMT_DSP) begin
        if (s_lr && !edge_lr) begin
          done = dsp_act && nbits != 5'd0;
          done_left = dsp_left;
          next_dsp_left = dsp_act ? ~dsp_left : 1'b1;
          next_dsp_act = 1'b1;
          next_nbits = 5'd0;
          next_sh = 24'h000000;
        end else if (!s_lr && dsp_act && nbits < 5'd24) begin
          next_sh = {sh[22:0], s_data};
          next_nbits = nbits + 5'd1;
        end
      end else begin
        if (s_lr != edge_lr) begin
          done = nbits != 5'd0;
          done_left = (format_active == sdc_pkg::FMT_I2S) ? ~edge_lr : edge_lr;
          idx = 6'd0;
          nb = 5'd0;
        end else if (bit_idx != 6'd63) begin
          idx = bit_idx + 6'd1;
        end
        next_idx = idx;
        next_nbits = nb;
        next_sh = (nb == 5'd0) ? 24'h000000 : sh;
        if (idx >= sdc_skip(format_active, ctrl_reg[sdc_pkg::CB_WLEN +: 2])
            && nb < 5'd24) begin
          next_sh = {next_sh[22:0], s_data};
          next_nbits = nb + 5'd1;
        end
      end
    end
    next_strobe = done;
    next_left = (done && done_left) ? aligned : left_sample;
    next_right = (done && !done_left) ? aligned : right_sample;
  end

  // Silence counters count channel clock periods since the last nonzero sample.
  logic             lr_tick;
  logic [CNT_W-1:0] cnt [2];
  logic [CNT_W-1:0] next_cnt [2];
  logic [1:0]       nz_clear, next_flag;
  assign lr_tick     = s_lr & ~prev_lr;
  assign nz_clear[0] = done & done_left & (aligned != 24'h000000);
  assign nz_clear[1] = done & ~done_left & (aligned != 24'h000000);
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (nz_clear[c]) next_cnt[c] = '0;
      else if (lr_tick && cnt[c] <= LIM) next_cnt[c] = cnt[c] + CNT_W'(1);
      else next_cnt[c] = cnt[c];
      next_flag[c] = next_cnt[c] > LIM;
    end
  end

  // Master clock ratio: pclk cycles per channel clock period, scaled to the 48 kHz base.
  logic [11:0] period_cnt, next_period;
  logic [13:0] norm;
  logic        next_fault;
  assign norm = {2'b00, period_cnt} << rate_mode;
  always_comb begin
    next_period = lr_tick ? 12'h001 : (period_cnt == 12'hfff ? period_cnt
                  : period_cnt + 12'h001);
    next_div = mclk_div_idx[1:0];
    next_fault = clock_fault;
    if (lr_tick) begin
      next_div = (norm < sdc_pkg::RATIO_T1) ? 2'h0 : (norm < sdc_pkg::RATIO_T2) ? 2'h1
                 : (norm < sdc_pkg::RATIO_T3) ? 2'h2 : 2'h3;
      next_fault = norm < sdc_pkg::RATIO_MIN || norm >= sdc_pkg::RATIO_MAX
                   || (norm >= sdc_pkg::RATIO_T1 && !ctrl_reg[sdc_pkg::CB_AUTODIV]);
    end
  end

  logic next_div_top;
  assign next_div_top = lr_tick ? (norm >= sdc_pkg::RATIO_T4) : mclk_div_idx[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_mode <= sdc_pkg::RATE_48;
      format_active <= sdc_pkg::FMT_RJ;
      deemph_active <= 1'b0;
      deemph_curve <= 2'h0;
      mute_out <= 1'b1;
      prev_bclk <= 1'b0;
      prev_lr <= 1'b0;
      edge_lr <= 1'b0;
      dsp_act <= 1'b0;
      dsp_left <= 1'b1;
      bit_idx <= 6'd0;
      nbits <= 5'd0;
      sh <= 24'h000000;
      sample_strobe <= 1'b0;
      left_sample <= 24'h000000;
      right_sample <= 24'h000000;
      cnt[0] <= '0;
      cnt[1] <= '0;
      left_silence_flag <= 1'b0;
      right_silence_flag <= 1'b0;
      period_cnt <= 12'h000;
      mclk_div_idx <= 3'h0;
      clock_fault <= 1'b0;
    end else begin
      rate_mode <= next_rate;
      format_active <= next_fmt;
      deemph_active <= next_deemphasis_enable;
      deemph_curve <= next_curve;
      mute_out <= next_mute;
      prev_bclk <= s_bclk;
      prev_lr <= s_lr;
      edge_lr <= next_edge_lr;
      dsp_act <= next_dsp_act;
      dsp_left <= next_dsp_left;
      bit_idx <= next_idx;
      nbits <= next_nbits;
      sh <= next_sh;
      sample_strobe <= next_strobe;
      left_sample <= next_left;
      right_sample <= next_right;
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
      left_silence_flag <= next_flag[0];
      right_silence_flag <= next_flag[1];
      period_cnt <= next_period;
      mclk_div_idx <= {next_div_top, next_div};
      clock_fault <= next_fault;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rate_192_or: assert property (
    (s_192 || ctrl_reg[11]) |=> rate_mode == sdc_pkg::RATE_192)
    else $error("192 kHz select not honoured");
  a_rate_96_or: assert property (
    (!s_192 && !ctrl_reg[11] && (s_96 || ctrl_reg[10])) |=> rate_mode == sdc_pkg::RATE_96)
    else $error("96 kHz select not honoured");
  a_right_flag_set: assert property (
    (lr_tick && cnt[1] == LIM && !nz_clear[1]) |=> right_silence_flag)
    else $error("right silence flag late");
  a_left_flag_set: assert property (
    (!left_silence_flag && !(lr_tick && cnt[0] == LIM)) |=> !left_silence_flag)
    else $error("left silence flag early");
  sequence s_left_nonzero;
    nz_clear[0] ##1 1'b1;
  endsequence
  a_left_flag_clear: assert property (
    s_left_nonzero |-> !left_silence_flag && cnt[0] == '0)
    else $error("nonzero left sample did not clear silence");
  a_mute_pin_follow: assert property (
    s_mute [*2] |-> mute_out)
    else $error("mute pin not applied");
  a_deemph_pin_follow: assert property (
    $changed(s_deemphasis_enable) |=> deemph_active == $past(s_deemphasis_enable))
    else $error("de-emphasis does not track pin");
  a_format_by_pins: assert property (
    (ctrl_reg[5:4] == 2'h0) |=> format_active == $past(s_fmt))
    else $error("format pins not honoured");
  a_autodiv_gate: assert property (
    (lr_tick && norm >= sdc_pkg::RATIO_T1 && !ctrl_reg[7]) |=> clock_fault ##1 mute_out)
    else $error("high clock ratio accepted without autodivide");
endmodule : sdc_top

// ===== test/sdc_src_model.sv
/*
  Audio source and controller model: left-justified frames back to back, control words.
  The bit clock comes in bursts of 24 pulses per half frame and rests low in between.
  Assumes pclk is the master clock; 8 pclk per bit clock gives 512 pclk per frame.
*/
`timescale 1ns/1ps
module sdc_src_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Words for the next frame.
  input  wire logic [23:0] left_word,
  input  wire logic [23:0] right_word,
  // Pins into the device.
  output logic             control_shift_clock,
  output logic             control_serial_in,
  output logic             control_word_latch,
  output logic             audio_bit_clock,
  output logic             audio_lr_clock,
  output logic             serial_audio_in
);
  // Idle levels at time zero.
  initial begin
    {control_shift_clock, control_serial_in, control_word_latch} = 3'h0;
    {audio_bit_clock, audio_lr_clock, serial_audio_in} = 3'h0;
  end

  // Frames run without pause, so the channel clock never stops at 512 pclk.
  always begin : frames
    logic [63:0] s;
    wait (presetn === 1'b1);
    s = {left_word, 8'h00, right_word, 8'h00};
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      audio_lr_clock <= (i < 32);
      serial_audio_in <= s[63-i];
      audio_bit_clock <= 1'b0;
      repeat (4) @(posedge pclk);
      audio_bit_clock <= (i % 32 < 24);
      repeat (3) @(posedge pclk);
    end
  end

  // Data changes while the shift clock is low; the latch rises after 16 bits.
  task automatic send_ctl(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      control_serial_in <= w[i];
      control_shift_clock <= 1'b0;
      repeat (4) @(posedge pclk);
      control_shift_clock <= 1'b1;
      repeat (3) @(posedge pclk);
    end
    @(posedge pclk);
    control_shift_clock <= 1'b0;
    control_serial_in <= ~w[0];
    control_word_latch <= 1'b1;
    repeat (4) @(posedge pclk);
    control_word_latch <= 1'b0;
  endtask : send_ctl
endmodule : sdc_src_model

// ===== test/test_sdc_top.sv
/*
  Self-checking bench for the converter control block: APB reads and writes, pins, audio.
  Assumes the source model keeps frames running and the silence limit is set to 4.
*/
`timescale 1ns/1ps
module test_sdc_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rate_192_sel, rate_96_sel, deemphasis_enable, mute_in, e;
  logic        input_format_sel_hi, input_format_sel_lo, clock_fault;
  logic        left_silence_flag, right_silence_flag, deemph_active, mute_out;
  logic [23:0] left_sample, right_sample, left_word, right_word;
  logic [1:0]  rate_mode, deemph_curve, format_active;
  logic [2:0]  mclk_div_idx;
  logic        control_shift_clock, control_serial_in, control_word_latch;
  logic        audio_bit_clock, audio_lr_clock, serial_audio_in, sample_strobe;
  int          error_cnt, total_checks, cyc, strobes;

  sdc_top #(.SILENCE_LIMIT(4)) sdc_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .control_shift_clock, .control_serial_in,
    .control_word_latch, .audio_bit_clock, .audio_lr_clock, .serial_audio_in, .rate_192_sel,
    .rate_96_sel, .deemphasis_enable, .mute_in, .input_format_sel_hi, .input_format_sel_lo,
    .left_silence_flag, .right_silence_flag, .left_sample, .right_sample, .sample_strobe,
    .vol_left(), .vol_right(), .rate_mode, .deemph_active, .deemph_curve, .mute_out,
    .format_active, .mclk_div_idx, .clock_fault);
  sdc_src_model sdc_src_model_i (.pclk, .presetn, .left_word, .right_word, .control_shift_clock,
    .control_serial_in, .control_word_latch, .audio_bit_clock, .audio_lr_clock, .serial_audio_in);

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // A hang is cut short well beyond the expected run length; word strobes are counted too.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    strobes <= strobes + int'(sample_strobe);
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Compares a value seen with the one expected and counts both outcomes.
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  // Reads a register and compares it.
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask : rd

  // Waits n master clock cycles.
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w

  // Register values after reset.
  task automatic defaults();
    rd("vol left", sdc_pkg::OFF_VOL_L, 32'h3fff);
    rd("vol right", sdc_pkg::OFF_VOL_R, 32'h3fff);
    rd("ctrl", sdc_pkg::OFF_CTRL, 32'h0080);
  endtask : defaults

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence of scenarios.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cyc, error_cnt, total_checks} = '0;
    {rate_192_sel, rate_96_sel, deemphasis_enable, mute_in} = 4'h0;
    {input_format_sel_hi, input_format_sel_lo} = 2'b10;
    {left_word, right_word} = {24'h123456, 24'h000000};
    w(20);
    presetn <= 1'b1;
    defaults();
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    w(4200);
    check("left sample", 32'(left_sample), 32'h123456);
    check("right flag", 32'(right_silence_flag), 32'h1);
    check("left flag", 32'(left_silence_flag), 32'h0);
    check("strobes", 32'(strobes >= 12 && strobes <= 20), 32'h1);
    {left_word, right_word} <= {24'h000000, 24'hfedcba};
    w(4200);
    check("right sample", 32'(right_sample), 32'hfedcba);
    check("right flag clr", 32'(right_silence_flag), 32'h0);
    check("left flag set", 32'(left_silence_flag), 32'h1);
    check("no fault", 32'(clock_fault), 32'h0);
    check("divide", 32'(mclk_div_idx), 32'h2);
    rd("status", sdc_pkg::OFF_STATUS, 32'h0a01);
    rd("right reg", sdc_pkg::OFF_RIGHT, 32'hfedcba);
    apb(1'b1, sdc_pkg::OFF_CTRL, 32'h0000);
    w(1200);
    check("fault no autodiv", 32'(clock_fault), 32'h1);
    check("fault mute", 32'(mute_out), 32'h1);
    apb(1'b1, sdc_pkg::OFF_CTRL, 32'h0080);
    w(1200);
    for (int i = 0; i < 4; i++) begin
      {rate_192_sel, rate_96_sel} <= i[1:0];
      {input_format_sel_hi, input_format_sel_lo} <= i[1:0];
      {mute_in, deemphasis_enable} <= i[1:0];
      w(8);
      check("rate pins", 32'(rate_mode), {30'h0, i[1], i == 1});
      check("format", 32'(format_active), 32'(i));
      check("deemph", 32'(deemph_active), 32'(i[0]));
      check("mute", 32'(mute_out), 32'(i[1]));
    end
    {rate_192_sel, rate_96_sel, mute_in} <= 3'h0;
    {input_format_sel_hi, input_format_sel_lo} <= 2'b10;
    for (int j = 1; j < 3; j++) begin
      apb(1'b1, sdc_pkg::OFF_CTRL, 32'h0080 | (32'h0200 << j) | 32'h0012);
      w(8);
      check("rate bits", 32'(rate_mode), 32'(j));
      check("curve", 32'(deemph_curve), 32'h2);
      check("format reg", 32'(format_active), 32'h1);
    end
    apb(1'b1, sdc_pkg::OFF_CTRL, 32'h0080);
    sdc_src_model_i.send_ctl({14'h1234, 2'b01});
    sdc_src_model_i.send_ctl({14'h0555, 2'b00});
    sdc_src_model_i.send_ctl({14'h2aaa, 2'b11});
    w(8);
    rd("serial vol right", sdc_pkg::OFF_VOL_R, 32'h1234);
    rd("serial vol left", sdc_pkg::OFF_VOL_L, 32'h0555);
    rd("ctrl kept", sdc_pkg::OFF_CTRL, 32'h0080);
    presetn <= 1'b0;
    w(3);
    presetn <= 1'b1;
    defaults();
    tally_and_finish();
  end
endmodule : test_sdc_top
